// ===== include/fcvr_consts.svh
`ifndef FCVR_CONSTS_SVH
`define FCVR_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define FCVR_IDX_CFG6 8'h10
`define FCVR_IDX_CFG7 8'h11
`define FCVR_IDX_V2V5 8'h20
`define FCVR_IDX_VCORE 8'h21
`define FCVR_IDX_VSUP 8'h22
`define FCVR_IDX_V5V0 8'h23
`define FCVR_IDX_V12 8'h24
`define FCVR_IDX_CFG1 8'h40
`define FCVR_IDX_IRQ_STAT 8'h41
`define FCVR_IDX_CORE_LIM 8'h46
`define FCVR_IDX_EXT1 8'h76
`define FCVR_IDX_EXT2 8'h77
`define FCVR_IDX_IRQ_MASK 8'h90

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FCVR_RST_CFG6 8'h00
`define FCVR_RST_CFG7 8'h00
`define FCVR_RST_RESULT 8'h00
`define FCVR_RST_CORE_LIM 8'h00
`define FCVR_RST_IRQ 3'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FCVR_CFG6_THERMAL_MAN 3
`define FCVR_CFG6_FOLLOWER 4
`define FCVR_CFG6_LEADER 5
`define FCVR_CFG6_CORE_LOW 6
`define FCVR_CFG6_EXTRA 7
`define FCVR_CFG7_HYS_DIS 0
`define FCVR_CFG1_LOCK 1
`define FCVR_IRQ_THERMAL 0
`define FCVR_IRQ_CORE_LOW 1
`define FCVR_IRQ_CORE_OK 2
`define FCVR_IRQ_W 3
`define FCVR_NUM_V 5

`endif

// ===== include/fcvr_pkg.sv
package fcvr_pkg;

  // ----------------------------------------
  // Core-low monitor states
  // ----------------------------------------
  typedef enum logic [2:0] {
    CL_NORMAL = 3'b001,
    CL_LOW = 3'b010,
    CL_SPINUP = 3'b100
  } fcvr_core_state_t;

  typedef logic [7:0] fcvr_byte_t;

endpackage

// ===== hdl/fcvr_voltage_freeze.sv
`timescale 1ns/1ps
`include "fcvr_consts.svh"

module fcvr_voltage_freeze #(
  parameter int NUM_V = `FCVR_NUM_V
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic meas_valid,
  input wire logic [NUM_V-1:0][9:0] meas,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_idx,
  output logic [NUM_V-1:0][7:0] result,
  output logic [7:0] ext1,
  output logic [7:0] ext2,
  output logic frozen
);

  logic [NUM_V-1:0] pend_q;
  logic ext_rd;
  logic [NUM_V-1:0] res_rd;

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  assign ext_rd = rd_strobe && (rd_idx == `FCVR_IDX_EXT1 || rd_idx == `FCVR_IDX_EXT2);
  always_comb begin
    for (int i = 0; i < NUM_V; i++) begin
      res_rd[i] = rd_strobe && (rd_idx == `FCVR_IDX_V2V5 + 8'(i));
    end
  end

  // ----------------------------------------
  // Freeze tracking
  // ----------------------------------------
  // Freeze until results read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else if (ext_rd) begin
      pend_q <= '1;
    end else begin
      pend_q <= pend_q & ~res_rd;
    end
  end
  assign frozen = |pend_q;

  // ----------------------------------------
  // Result storage
  // ----------------------------------------
  // Eight MSBs per input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= '0;
      ext1 <= `FCVR_RST_RESULT;
      ext2 <= `FCVR_RST_RESULT;
    end else if (meas_valid && !frozen && !ext_rd) begin
      for (int i = 0; i < NUM_V; i++) begin
        result[i] <= meas[i][9:2];
      end
      ext1 <= {meas[3][1:0], meas[2][1:0], meas[1][1:0], meas[0][1:0]};
      ext2 <= {6'h00, meas[4][1:0]};
    end
  end

endmodule

// ===== hdl/fcvr_core_low_monitor.sv
`timescale 1ns/1ps

module fcvr_core_low_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mode_en,
  input wire logic sample_valid,
  input wire logic [7:0] core_sample,
  input wire logic [7:0] low_limit,
  input wire logic spinup_done,
  output logic low_event,
  output logic ok_event,
  output logic processor_hot_en,
  output logic spinup_req
);

  fcvr_pkg::fcvr_core_state_t state_q;
  fcvr_pkg::fcvr_core_state_t state_d;

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      fcvr_pkg::CL_NORMAL: begin
        if (mode_en && sample_valid && core_sample < low_limit) begin
          state_d = fcvr_pkg::CL_LOW;
        end
      end
      fcvr_pkg::CL_LOW: begin
        if (!mode_en || (sample_valid && core_sample > low_limit)) begin
          state_d = fcvr_pkg::CL_SPINUP;
        end
      end
      fcvr_pkg::CL_SPINUP: begin
        if (spinup_done) begin
          state_d = fcvr_pkg::CL_NORMAL;
        end
      end
      default: begin
        state_d = fcvr_pkg::CL_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= fcvr_pkg::CL_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_event <= 1'b0;
      ok_event <= 1'b0;
      processor_hot_en <= 1'b1;
      spinup_req <= 1'b0;
    end else begin
      low_event <= (state_q == fcvr_pkg::CL_NORMAL) && (state_d == fcvr_pkg::CL_LOW);
      ok_event <= (state_q == fcvr_pkg::CL_LOW) && (state_d == fcvr_pkg::CL_SPINUP);
      processor_hot_en <= (state_d != fcvr_pkg::CL_LOW);
      spinup_req <= (state_d == fcvr_pkg::CL_SPINUP);
    end
  end

endmodule

// ===== hdl/fcvr_top.sv
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "fcvr_consts.svh"

// Behaviour
// - Bit 0 sets fan 1 smoothing x4 for remote 1
// - Bit 1 sets fan 2 smoothing x4 for local channel
// - Bit 2 sets fan 3 smoothing x4 for remote 2
// - Bit 3 keeps thermal override active in manual fan mode
// - Bit 4 selects fan sync follower role
// - Bit 5 selects fan sync leader role
// - Core low in standby mode flags status, alerts, disables processor-hot
// - Core recovery re-enables processor-hot and spins fans up
// - Bit 7 lengthens all smoothing times a further 39.2 percent
// - Thermal limit event overrides fan settings, even disabled, except in manual fan mode with bit 3 clear
// - Second config bit 0 removes thermal limit hysteresis
// - Lock makes second config register ignore writes
// - Five read-only voltage results hold eight MSBs each
// - Extended read freezes extended and result registers until read
// - Both configs and voltage results reset to zero
// - Lock bit writes once, holds until power cycle
module fcvr_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic meas_valid,
  input wire logic [9:0] meas_2v5,
  input wire logic [9:0] meas_core,
  input wire logic [9:0] meas_supply,
  input wire logic [9:0] meas_5v0,
  input wire logic [9:0] meas_12v,
  input wire logic fan_manual_mode,
  input wire logic thermal_limit_in,
  input wire logic thermal_below_hyst,
  input wire logic spinup_done,
  output logic [2:0] fan_smooth_x4,
  output logic fan_smooth_extra,
  output logic fan_sync_follower,
  output logic fan_sync_leader,
  output logic thermal_hysteresis_disable,
  output logic fan_thermal_override,
  output logic processor_hot_monitor_en,
  output logic fan_spinup_req,
  output logic limits_locked,
  output logic irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] cfg6_q;
  logic [7:0] cfg7_q;
  logic [7:0] core_lim_q;
  logic lock_q;
  logic [`FCVR_IRQ_W-1:0] stat_q;
  logic [`FCVR_IRQ_W-1:0] stat_d;
  logic [`FCVR_IRQ_W-1:0] mask_q;
  logic [`FCVR_IRQ_W-1:0] stat_set;
  logic [`FCVR_IRQ_W-1:0] stat_clr;
  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic acc;
  logic rd_acc;
  logic wr_acc;
  logic [7:0] rd_idx;
  logic [7:0] wr_idx;
  logic wr_ok;
  fcvr_pkg::fcvr_byte_t rd_byte;
  logic [4:0][9:0] meas;
  logic [4:0][7:0] result;
  logic [7:0] ext1;
  logic [7:0] ext2;
  logic frozen;
  logic core_low_ev;
  logic core_ok_ev;
  logic processor_hot_en;
  logic spinup_req;
  logic thermal_in_q;
  logic thermal_active_q;

  // ----------------------------------------
  // Address helpers
  // ----------------------------------------
  function automatic logic fcvr_addr_ok(input logic [31:0] a);
    return (a[31:10] == 22'h000000) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [7:0] fcvr_index(input logic [31:0] a);
    return a[9:2];
  endfunction

  // ----------------------------------------
  // Bus access decode
  // ----------------------------------------
  assign acc = hsel && hready && htrans[1];
  assign rd_acc = acc && !hwrite;
  assign wr_acc = acc && hwrite;
  assign rd_idx = fcvr_addr_ok(haddr) ? fcvr_index(haddr) : 8'hff;
  assign wr_idx = fcvr_index(wr_addr_q);
  assign wr_ok = wr_pend_q && fcvr_addr_ok(wr_addr_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h00000000;
    end else begin
      wr_pend_q <= wr_acc;
      if (wr_acc) begin
        wr_addr_q <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    case (rd_idx)
      `FCVR_IDX_CFG6: rd_byte = cfg6_q;
      `FCVR_IDX_CFG7: rd_byte = cfg7_q;
      `FCVR_IDX_V2V5: rd_byte = result[0];
      `FCVR_IDX_VCORE: rd_byte = result[1];
      `FCVR_IDX_VSUP: rd_byte = result[2];
      `FCVR_IDX_V5V0: rd_byte = result[3];
      `FCVR_IDX_V12: rd_byte = result[4];
      `FCVR_IDX_CFG1: rd_byte = {6'h00, lock_q, 1'b0};
      `FCVR_IDX_IRQ_STAT: rd_byte = {5'h00, stat_q};
      `FCVR_IDX_CORE_LIM: rd_byte = core_lim_q;
      `FCVR_IDX_EXT1: rd_byte = ext1;
      `FCVR_IDX_EXT2: rd_byte = ext2;
      `FCVR_IDX_IRQ_MASK: rd_byte = {5'h00, mask_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_acc) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Power-on zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg6_q <= `FCVR_RST_CFG6;
    end else if (wr_ok && wr_idx == `FCVR_IDX_CFG6) begin
      cfg6_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg7_q <= `FCVR_RST_CFG7;
    end else if (wr_ok && wr_idx == `FCVR_IDX_CFG7 && !lock_q) begin
      cfg7_q <= {7'h00, hwdata[`FCVR_CFG7_HYS_DIS]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_lim_q <= `FCVR_RST_CORE_LIM;
    end else if (wr_ok && wr_idx == `FCVR_IDX_CORE_LIM && !lock_q) begin
      core_lim_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_q <= 1'b0;
    end else if (wr_ok && wr_idx == `FCVR_IDX_CFG1 && hwdata[`FCVR_CFG1_LOCK]) begin
      lock_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= `FCVR_RST_IRQ;
    end else if (wr_ok && wr_idx == `FCVR_IDX_IRQ_MASK) begin
      mask_q <= hwdata[`FCVR_IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // Voltage results
  // ----------------------------------------
  assign meas[0] = meas_2v5;
  assign meas[1] = meas_core;
  assign meas[2] = meas_supply;
  assign meas[3] = meas_5v0;
  assign meas[4] = meas_12v;

  fcvr_voltage_freeze #(
    .NUM_V(`FCVR_NUM_V)
  ) u_freeze (
    .clk(hclk),
    .rst_n(hresetn),
    .meas_valid(meas_valid),
    .meas(meas),
    .rd_strobe(rd_acc),
    .rd_idx(rd_idx),
    .result(result),
    .ext1(ext1),
    .ext2(ext2),
    .frozen(frozen)
  );

  // ----------------------------------------
  // Core voltage low handling
  // ----------------------------------------
  // Standby core-low monitor
  fcvr_core_low_monitor u_core_low (
    .clk(hclk),
    .rst_n(hresetn),
    .mode_en(cfg6_q[`FCVR_CFG6_CORE_LOW]),
    .sample_valid(meas_valid),
    .core_sample(meas_core[9:2]),
    .low_limit(core_lim_q),
    .spinup_done(spinup_done),
    .low_event(core_low_ev),
    .ok_event(core_ok_ev),
    .processor_hot_en(processor_hot_en),
    .spinup_req(spinup_req)
  );

  // ----------------------------------------
  // Thermal limit tracking
  // ----------------------------------------
  // Hysteresis bypass
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thermal_in_q <= 1'b0;
      thermal_active_q <= 1'b0;
    end else begin
      thermal_in_q <= thermal_limit_in;
      if (thermal_limit_in) begin
        thermal_active_q <= 1'b1;
      end else if (cfg7_q[`FCVR_CFG7_HYS_DIS] || thermal_below_hyst) begin
        thermal_active_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  always_comb begin
    stat_set = '0;
    stat_set[`FCVR_IRQ_THERMAL] = thermal_limit_in && !thermal_in_q;
    stat_set[`FCVR_IRQ_CORE_LOW] = core_low_ev;
    stat_set[`FCVR_IRQ_CORE_OK] = core_ok_ev;
    stat_clr = '0;
    if (wr_ok && wr_idx == `FCVR_IDX_IRQ_STAT) begin
      stat_clr = hwdata[`FCVR_IRQ_W-1:0];
    end
    stat_d = (stat_q & ~stat_clr) | stat_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= `FCVR_RST_IRQ;
      irq <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq <= |(stat_d & mask_q);
    end
  end

  // ----------------------------------------
  // Fan control outputs
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fan_smooth_x4 <= 3'h0;
      fan_smooth_extra <= 1'b0;
      fan_sync_follower <= 1'b0;
      fan_sync_leader <= 1'b0;
      thermal_hysteresis_disable <= 1'b0;
      limits_locked <= 1'b0;
    end else begin
      fan_smooth_x4 <= cfg6_q[2:0];
      fan_smooth_extra <= cfg6_q[`FCVR_CFG6_EXTRA];
      fan_sync_follower <= cfg6_q[`FCVR_CFG6_FOLLOWER];
      fan_sync_leader <= cfg6_q[`FCVR_CFG6_LEADER];
      thermal_hysteresis_disable <= cfg7_q[`FCVR_CFG7_HYS_DIS];
      limits_locked <= lock_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fan_thermal_override <= 1'b0;
      processor_hot_monitor_en <= 1'b1;
      fan_spinup_req <= 1'b0;
    end else begin
      fan_thermal_override <= thermal_active_q &&
        (!fan_manual_mode || cfg6_q[`FCVR_CFG6_THERMAL_MAN]);
      processor_hot_monitor_en <= processor_hot_en;
      fan_spinup_req <= spinup_req;
    end
  end

endmodule

// ===== tb/fcvr_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module fcvr_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic meas_valid,
  input wire logic fan_manual_mode,
  input wire logic thermal_limit_in,
  input wire logic spinup_done,
  input wire logic [2:0] fan_smooth_x4,
  input wire logic fan_smooth_extra,
  input wire logic fan_sync_follower,
  input wire logic fan_sync_leader,
  input wire logic thermal_hysteresis_disable,
  input wire logic fan_thermal_override,
  input wire logic processor_hot_monitor_en,
  input wire logic fan_spinup_req,
  input wire logic limits_locked
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_bus_okay: assert property (!hresp)
    else $error("error response on bus");
  chk_no_wait: assert property ($past(hresetn) |-> hreadyout)
    else $error("wait state inserted");
  chk_mirror_cause: assert property ($changed({fan_smooth_extra, fan_sync_leader,
    fan_sync_follower, fan_smooth_x4}) |-> $past(hwrite, 3) && $past(htrans[1], 3))
    else $error("config output changed without write");
  chk_lock_sticky: assert property (limits_locked |=> limits_locked)
    else $error("lock released");
  chk_lock_cause: assert property ($rose(limits_locked) |-> $past(hwrite, 3) && $past(htrans[1], 3))
    else $error("lock set without write");
  chk_hys_frozen: assert property ($past(limits_locked) |-> $stable(thermal_hysteresis_disable))
    else $error("locked register changed");
  chk_thermal_override: assert property (thermal_limit_in && !fan_manual_mode ##1 !fan_manual_mode
    |=> fan_thermal_override)
    else $error("thermal event did not override fans");
  chk_low_cause: assert property ($fell(processor_hot_monitor_en)
    |-> $past(meas_valid, 1) || $past(meas_valid, 2))
    else $error("monitor disabled without sample");
  chk_spin_monitor: assert property (fan_spinup_req |-> processor_hot_monitor_en)
    else $error("spin-up with monitor off");
  chk_spin_end: assert property (fan_spinup_req && spinup_done |-> ##[1:2] !fan_spinup_req)
    else $error("spin-up did not end");
endmodule

bind fcvr_top fcvr_props chk_u (
  .hclk(hclk), .hresetn(hresetn), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp),
  .meas_valid(meas_valid), .fan_manual_mode(fan_manual_mode),
  .thermal_limit_in(thermal_limit_in), .spinup_done(spinup_done),
  .fan_smooth_x4(fan_smooth_x4), .fan_smooth_extra(fan_smooth_extra),
  .fan_sync_follower(fan_sync_follower), .fan_sync_leader(fan_sync_leader),
  .thermal_hysteresis_disable(thermal_hysteresis_disable),
  .fan_thermal_override(fan_thermal_override),
  .processor_hot_monitor_en(processor_hot_monitor_en), .fan_spinup_req(fan_spinup_req),
  .limits_locked(limits_locked)
);

// ===== tb/fcvr_host_model.sv
`timescale 1ns/1ps
`include "fcvr_consts.svh"
// ----------------------------------------
// Host bus master
// ----------------------------------------
module fcvr_host_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic rd_valid,
  output logic [31:0] rd_data
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_valid = 1'b0;
    rd_data = 32'h0;
  end
  always @(posedge hclk) begin
    if (rd_valid) begin
      rd_valid <= 1'b0;
    end
  end
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    haddr <= ~haddr;
    hwdata <= {24'h0, (idx == `FCVR_IDX_CFG7) ? (d & 8'h01) : d};
    do @(posedge hclk); while (hready !== 1'b1);
    hwdata <= ~hwdata;
    rd_valid <= !wr;
    rd_data <= hrdata;
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "fcvr_consts.svh"
module tb;
  logic hclk, hresetn, meas_valid, fan_manual_mode, thermal_limit_in, thermal_below_hyst;
  logic spinup_done, hsel, hwrite, hreadyout, hresp, rd_valid, fan_smooth_extra;
  logic fan_sync_follower, fan_sync_leader, thermal_hysteresis_disable, fan_thermal_override;
  logic processor_hot_monitor_en, fan_spinup_req, limits_locked, irq;
  logic [31:0] haddr, hwdata, hrdata, rd_data;
  logic [1:0] htrans;
  logic [2:0] hsize, fan_smooth_x4;
  logic [9:0] mv [5];
  logic [9:0] old [5];
  logic [31:0] exp_q [$];
  logic [7:0] v;
  int n_fail, n_compared, seed, i;
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  fcvr_host_model host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .rd_valid(rd_valid), .rd_data(rd_data));
  fcvr_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .meas_valid(meas_valid),
    .meas_2v5(mv[0]), .meas_core(mv[1]), .meas_supply(mv[2]), .meas_5v0(mv[3]),
    .meas_12v(mv[4]), .fan_manual_mode(fan_manual_mode), .thermal_limit_in(thermal_limit_in),
    .thermal_below_hyst(thermal_below_hyst), .spinup_done(spinup_done),
    .fan_smooth_x4(fan_smooth_x4), .fan_smooth_extra(fan_smooth_extra),
    .fan_sync_follower(fan_sync_follower), .fan_sync_leader(fan_sync_leader),
    .thermal_hysteresis_disable(thermal_hysteresis_disable),
    .fan_thermal_override(fan_thermal_override),
    .processor_hot_monitor_en(processor_hot_monitor_en), .fan_spinup_req(fan_spinup_req),
    .limits_locked(limits_locked), .irq(irq));
  // ----------------------------------------
  // Compare and stimulus tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge hclk) begin
    if (rd_valid === 1'b1) begin
      cmp(rd_data, exp_q.pop_front());
    end
  end
  task automatic rdx(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    host_u.xfer(1'b0, idx, 8'h00);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host_u.xfer(1'b1, idx, d);
  endtask
  task automatic settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask
  task automatic meas_new(input logic [9:0] core);
    @(posedge hclk);
    for (int k = 0; k < 5; k++) mv[k] <= (k == 1) ? core : 10'($random(seed));
    meas_valid <= 1'b1;
    @(posedge hclk);
    meas_valid <= 1'b0;
  endtask
  task automatic summarize;
    n_fail += (exp_q.size() != 0);
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    summarize;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h0ca4;
    hresetn = 1'b0;
    meas_valid = 1'b0;
    fan_manual_mode = 1'b0;
    thermal_limit_in = 1'b0;
    thermal_below_hyst = 1'b0;
    spinup_done = 1'b0;
    for (int k = 0; k < 5; k++) mv[k] = 10'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdx(`FCVR_IDX_CFG6, 8'h00);
    rdx(`FCVR_IDX_CFG7, 8'h00);
    for (i = 0; i < 5; i++) rdx(`FCVR_IDX_V2V5 + i[7:0], 8'h00);
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'hff : 8'($random(seed));
      wr(`FCVR_IDX_CFG6, v);
      rdx(`FCVR_IDX_CFG6, v);
      settle;
      cmp({fan_smooth_extra, 1'b0, fan_sync_leader, fan_sync_follower, 1'b0, fan_smooth_x4},
        v & 8'hb7);
    end
    wr(`FCVR_IDX_CFG7, 8'hff);
    rdx(`FCVR_IDX_CFG7, 8'h01);
    for (i = 0; i < 3; i++) begin
      wr(`FCVR_IDX_CFG6, (i == 2) ? 8'h08 : 8'h00);
      @(posedge hclk);
      fan_manual_mode <= (i != 0);
      thermal_limit_in <= 1'b1;
      settle;
      cmp(fan_thermal_override, i != 1);
      @(posedge hclk);
      thermal_limit_in <= 1'b0;
      settle;
      cmp({thermal_hysteresis_disable, fan_thermal_override}, 2'b10);
    end
    wr(`FCVR_IDX_CFG7, 8'h00);
    @(posedge hclk);
    thermal_limit_in <= 1'b1;
    @(posedge hclk);
    thermal_limit_in <= 1'b0;
    settle;
    cmp(fan_thermal_override, 1'b1);
    @(posedge hclk);
    thermal_below_hyst <= 1'b1;
    settle;
    cmp(fan_thermal_override, 1'b0);
    wr(`FCVR_IDX_CFG6, 8'h00);
    meas_new(10'($random(seed)));
    settle;
    for (i = 0; i < 5; i++) rdx(`FCVR_IDX_V2V5 + i[7:0], mv[i][9:2]);
    rdx(`FCVR_IDX_EXT2, {6'h0, mv[4][1:0]});
    old = mv;
    meas_new(10'($random(seed)));
    wr(`FCVR_IDX_V2V5, 8'h5a);
    rdx(`FCVR_IDX_EXT1, {old[3][1:0], old[2][1:0], old[1][1:0], old[0][1:0]});
    for (i = 0; i < 5; i++) rdx(`FCVR_IDX_V2V5 + i[7:0], old[i][9:2]);
    meas_new(10'($random(seed)));
    settle;
    for (i = 0; i < 5; i++) rdx(`FCVR_IDX_V2V5 + i[7:0], mv[i][9:2]);
    wr(`FCVR_IDX_CORE_LIM, 8'h80);
    wr(`FCVR_IDX_IRQ_MASK, 8'h02);
    wr(`FCVR_IDX_CFG6, 8'h40);
    wr(`FCVR_IDX_IRQ_STAT, 8'h07);
    meas_new(10'h0fc);
    settle;
    cmp({processor_hot_monitor_en, irq}, 2'b01);
    rdx(`FCVR_IDX_IRQ_STAT, 8'h02);
    wr(`FCVR_IDX_IRQ_STAT, 8'h02);
    settle;
    cmp(irq, 1'b0);
    meas_new(10'h300);
    settle;
    cmp({processor_hot_monitor_en, fan_spinup_req, irq}, 3'b110);
    rdx(`FCVR_IDX_IRQ_STAT, 8'h04);
    @(posedge hclk);
    spinup_done <= 1'b1;
    @(posedge hclk);
    spinup_done <= 1'b0;
    settle;
    cmp({processor_hot_monitor_en, fan_spinup_req}, 2'b10);
    wr(`FCVR_IDX_CFG7, 8'h01);
    wr(`FCVR_IDX_CFG1, 8'h02);
    wr(`FCVR_IDX_CFG7, 8'h00);
    rdx(`FCVR_IDX_CFG7, 8'h01);
    wr(`FCVR_IDX_CFG1, 8'h00);
    rdx(`FCVR_IDX_CFG1, 8'h02);
    rdx(8'h55, 8'h00);
    settle;
    cmp(limits_locked, 1'b1);
    summarize;
  end
endmodule
